// >>> inc/smw_map.vh
// Mode codes, timing counts and field positions of the mode/wake controller
`ifndef SMW_MAP_VH
`define SMW_MAP_VH

// ----------------------------------------------------------------------
// Mode codes written by the host into the control and check registers
// ----------------------------------------------------------------------
`define SMW_CMD_NORMAL      3'h1
`define SMW_CMD_STANDBY     3'h2
`define SMW_CMD_SLEEP       3'h4

// ----------------------------------------------------------------------
// Local wake input option codes, two bits per input
// ----------------------------------------------------------------------
`define SMW_OPT_NONE        2'h0
`define SMW_OPT_HIGH        2'h1
`define SMW_OPT_LOW         2'h2
`define SMW_OPT_CHANGE      2'h3

// ----------------------------------------------------------------------
// Interrupt source bit positions
// ----------------------------------------------------------------------
`define SMW_IRQ_BAT_OVER    0
`define SMW_IRQ_BAT_UNDER   1
`define SMW_IRQ_REG_HOT     2
`define SMW_IRQ_REG_WARN    3
`define SMW_IRQ_CAN_FAIL    4
`define SMW_IRQ_SPI_ERR     5
`define SMW_IRQ_LOCAL_WAKE  6
`define SMW_IRQ_BUS_WAKE    7

// ----------------------------------------------------------------------
// Times in their own units, clock 20 MHz
// ----------------------------------------------------------------------
`define SMW_CLK_KHZ         20000
`define SMW_RST_PULSE_US    1000
`define SMW_NREQ_TMO_MS     75
`define SMW_V1LOW_SLEEP_MS  100
`define SMW_RST_PULSE_CYC   ((`SMW_RST_PULSE_US * `SMW_CLK_KHZ) / 1000)
`define SMW_NREQ_TMO_CYC    (`SMW_NREQ_TMO_MS * `SMW_CLK_KHZ)
`define SMW_V1LOW_CYC       (`SMW_V1LOW_SLEEP_MS * `SMW_CLK_KHZ)

`endif

// >>> src/smw_sync.v
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module smw_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // smw_sync

// >>> src/smw_wake_detect.v
// Per-input local wake detection for the three wake inputs
`timescale 1ns/1ps
`include "smw_map.vh"
module smw_wake_detect (
    input  wire       clk,
    input  wire       rstn,
    input  wire [2:0] pin_level,
    input  wire [5:0] option,
    input  wire       enable,
    output wire [2:0] wake_hit
);
    // --------------------------------------------------------------
    // Detection per input; change mode keeps its own reference level
    // --------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : g_in
            reg        ref_reg;
            reg  [1:0] opt_prev_reg;
            wire [1:0] opt = option[2*i+1:2*i];
            reg        hit;
            always @*
            begin
                case (opt)
                    `SMW_OPT_HIGH:   hit = pin_level[i];
                    `SMW_OPT_LOW:    hit = ~pin_level[i];
                    `SMW_OPT_CHANGE: hit = (pin_level[i] != ref_reg) &&
                                          (opt_prev_reg == `SMW_OPT_CHANGE);
                    default:         hit = 1'b0;
                endcase
            end
            // Reference is taken when the option is programmed and
            // after each detected change
            always @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    ref_reg      <= 1'b0;
                    opt_prev_reg <= 2'h0;
                end
                else
                begin
                    opt_prev_reg <= opt;
                    if (opt_prev_reg != `SMW_OPT_CHANGE || (hit && enable))
                        ref_reg <= pin_level[i];
                end
            end
            assign wake_hit[i] = hit & enable;
        end
    endgenerate
endmodule // smw_wake_detect

// >>> src/smw_mode_ctrl.v
// Operating-mode sequencer with wake, reset and interrupt handling
//
// Contract
// - Normal/Stand-by detect local wakes always; switched-supply contacts need switch on.
// - Sleep: only battery-wired contacts detect continuously; others via cyclic sense.
// - Normal/Stand-by expose live wake pin levels regardless of option.
// - Local wake in Normal/Stand-by sets status flag and unmasked interrupt.
// - Local wake in Sleep sets flag, enters Normal Request with reset.
// - Sleep with regulator off: chip-select fall wakes, sets second status flag.
// - Interrupt from eight failure and wake sources, each individually masked.
// - Entering Reset State drives reset pin low for 1 ms.
// - Reset pin released by host after holding low gives Normal Request.
// - Four ground-shift thresholds chosen by host level field; result readable.
// - At transmit falling edge, bus-high below threshold sets shift flag.
// - Normal Request needs watchdog write within 75 ms, else Sleep.
// - Normal watchdog miss or out-of-window write sends to Reset State.
// - Host writes of Sleep/Normal/Stand-by take effect only when control and check codes match.
// - Sleep exits on bus, forced, cyclic, local or chip-select wake.
// - Regulator low over 100 ms leads to Sleep only in one variant.
`timescale 1ns/1ps
`include "smw_map.vh"
module smw_mode_ctrl #(
    parameter V1LOW_SLEEP_EN = 0,
    parameter NREQ_TMO_CYC   = `SMW_NREQ_TMO_CYC,
    parameter V1LOW_CYC      = `SMW_V1LOW_CYC
) (
    input  wire       clk,
    input  wire       rstn,
    // Host register writes, one-cycle strobes on clk
    input  wire       mode_wr,
    input  wire [2:0] mode_control_reg,
    input  wire [2:0] mode_check_reg,
    input  wire       wdog_wr,
    input  wire       wdog_window_ok,
    input  wire       wdog_expired,
    input  wire [5:0] wake_input_config_reg,
    input  wire       wake_to_switched,
    input  wire [1:0] ground_offset_level_reg,
    input  wire [7:0] irq_mask,
    input  wire       wake_status_clr,
    input  wire       irq_status_second_clr,
    input  wire       shift_flag_clr,
    // Asynchronous pins and analog comparators
    input  wire [2:0] local_wake_inputs,
    input  wire       cs_n,
    input  wire       rst_pin_in,
    input  wire       main_regulator_low,
    input  wire       main_regulator_off,
    input  wire       can_tx,
    input  wire [3:0] canh_below_level,
    input  wire [5:0] fault_events,
    input  wire       bus_wake,
    input  wire       forced_wake,
    input  wire       cyclic_wake,
    // Outputs
    output reg  [5:0] mode_reg,
    output reg        rst_pin_out,
    output reg        rst_pin_oe_n,
    output reg        int_n_reg,
    output reg        main_regulator_en_reg,
    output reg        aux_regulator_en_reg,
    output reg        switched_battery_output_reg,
    output reg  [2:0] wake_input_status_reg,
    output reg  [2:0] wake_input_live_state_reg,
    output reg        irq_status_second_reg,
    output reg        shift_flag_reg,
    output reg        wdog_run_reg
);
    // ----------------------------------------------------------------
    // States, one-hot
    // ----------------------------------------------------------------
    localparam [5:0] ST_RESET   = 6'h01;
    localparam [5:0] ST_NREQ    = 6'h02;
    localparam [5:0] ST_NORMAL  = 6'h04;
    localparam [5:0] ST_STANDBY = 6'h08;
    localparam [5:0] ST_SLEEP   = 6'h10;
    localparam [5:0] ST_EMERG   = 6'h20;
    localparam [31:0] RST_CYC   = `SMW_RST_PULSE_CYC;
    localparam [31:0] NREQ_CYC  = NREQ_TMO_CYC;
    localparam [31:0] LOW_CYC   = V1LOW_CYC;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    wire [2:0] lw_s;
    wire [3:0] gs_s;
    wire [5:0] flt_s;
    wire [9:0] misc_s;
    smw_sync #(.W(3)) u_sync_lw (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (local_wake_inputs),
        .sync_out (lw_s)
    );
    smw_sync #(.W(4)) u_sync_gs (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (canh_below_level),
        .sync_out (gs_s)
    );
    smw_sync #(.W(6)) u_sync_flt (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (fault_events),
        .sync_out (flt_s)
    );
    smw_sync #(.W(10)) u_sync_misc (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({cs_n, rst_pin_in, main_regulator_low,
                    main_regulator_off, can_tx, bus_wake, forced_wake,
                    cyclic_wake, 2'b00}),
        .sync_out (misc_s)
    );
    wire cs_s     = misc_s[9];
    wire rpin_s   = misc_s[8];
    wire v1low_s  = misc_s[7];
    wire v1off_s  = misc_s[6];
    wire tx_s     = misc_s[5];
    wire bwake_s  = misc_s[4];
    wire fwake_s  = misc_s[3];
    wire cwake_s  = misc_s[2];

    // ----------------------------------------------------------------
    // Edge history
    // ----------------------------------------------------------------
    reg cs_prev_reg;
    reg tx_prev_reg;
    reg rpin_prev_reg;
    reg [31:0] cnt_reg;
    reg [31:0] low_cnt_reg;
    reg [7:0]  irq_pend_reg;

    wire cs_fall   = cs_prev_reg & ~cs_s;
    wire tx_fall   = tx_prev_reg & ~tx_s;
    wire rpin_rise = ~rpin_prev_reg & rpin_s;

    // ----------------------------------------------------------------
    // Local wake detection
    // ----------------------------------------------------------------
    wire awake_mode = mode_reg[2] | mode_reg[3];
    // Switched contacts only count while the switch is on; in Sleep
    // they are left to the cyclic-sense path
    wire lw_enable = (awake_mode &&
                      (!wake_to_switched || switched_battery_output_reg))
                     || (mode_reg == ST_SLEEP && !wake_to_switched);
    wire [2:0] lw_hit;
    smw_wake_detect u_wake (
        .clk       (clk),
        .rstn      (rstn),
        .pin_level (lw_s),
        .option    (wake_input_config_reg),
        .enable    (lw_enable),
        .wake_hit  (lw_hit)
    );

    wire spi_wake  = (mode_reg == ST_SLEEP) && v1off_s && cs_fall;
    wire any_wake  = (|lw_hit) || spi_wake || bwake_s || fwake_s ||
                     cwake_s;
    wire mode_ok   = mode_wr && (mode_control_reg == mode_check_reg);

    // ----------------------------------------------------------------
    // Mode sequencer
    // ----------------------------------------------------------------
    reg [5:0] mode_next;
    always @*
    begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_RESET:
                if (cnt_reg >= RST_CYC - 32'h1 && rpin_s)
                    mode_next = ST_NREQ;
            ST_NREQ:
                if (v1low_s)
                    mode_next = ST_RESET;
                else if (cnt_reg >= NREQ_CYC - 32'h1)
                    mode_next = ST_SLEEP;
                else if (!rpin_s)
                    mode_next = ST_RESET;
                else if (mode_ok &&
                         mode_control_reg == `SMW_CMD_NORMAL)
                    mode_next = ST_NORMAL;
            ST_NORMAL, ST_STANDBY:
                if (v1low_s || (wdog_wr && !wdog_window_ok) || wdog_expired)
                    mode_next = ST_RESET;
                else if (!rpin_s)
                    mode_next = ST_RESET;
                else if (mode_ok)
                    case (mode_control_reg)
                        `SMW_CMD_NORMAL:  mode_next = ST_NORMAL;
                        `SMW_CMD_STANDBY: mode_next = ST_STANDBY;
                        `SMW_CMD_SLEEP:   mode_next = ST_SLEEP;
                        default:          mode_next = mode_reg;
                    endcase
            ST_SLEEP:
                if (any_wake)
                    mode_next = ST_RESET;
            ST_EMERG:
                if (!v1low_s)
                    mode_next = ST_RESET;
            default:
                mode_next = ST_RESET;
        endcase
        // Long undervoltage parks the device in Sleep on one variant
        if (V1LOW_SLEEP_EN != 0 && low_cnt_reg >= LOW_CYC - 32'h1 &&
            mode_reg != ST_SLEEP)
            mode_next = ST_SLEEP;
    end

    // ----------------------------------------------------------------
    // State, timers and flags
    // ----------------------------------------------------------------
    wire [7:0] irq_src = {bwake_s && awake_mode, |lw_hit && awake_mode,
                          flt_s};
    wire [2:0] ws_set  = lw_hit;
    wire       gs_hit  = tx_fall && gs_s[ground_offset_level_reg];

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_reg                    <= ST_RESET;
            cnt_reg                     <= 32'h0;
            low_cnt_reg                 <= 32'h0;
            // Synchronisers reset low, so history starts low too and
            // no false falling edge follows reset
            cs_prev_reg                 <= 1'b0;
            tx_prev_reg                 <= 1'b0;
            rpin_prev_reg               <= 1'b0;
            wake_input_status_reg       <= 3'h0;
            wake_input_live_state_reg   <= 3'h0;
            irq_status_second_reg       <= 1'b0;
            shift_flag_reg              <= 1'b0;
            irq_pend_reg                <= 8'h0;
        end
        else
        begin
            mode_reg      <= mode_next;
            cs_prev_reg   <= cs_s;
            tx_prev_reg   <= tx_s;
            rpin_prev_reg <= rpin_s;
            // Normal Request counts from entry; a watchdog write
            // restarts the count
            if (mode_next != mode_reg ||
                (mode_reg == ST_NREQ && wdog_wr))
                cnt_reg <= 32'h0;
            else if (cnt_reg != 32'hFFFFFFFF)
                cnt_reg <= cnt_reg + 32'h1;
            low_cnt_reg <= v1low_s ? low_cnt_reg + {31'h0,
                           low_cnt_reg != 32'hFFFFFFFF} : 32'h0;
            if (awake_mode)
                wake_input_live_state_reg <= lw_s;
            // Set wins over a clear in the same cycle
            wake_input_status_reg <= (wake_status_clr ? 3'h0 :
                                      wake_input_status_reg) | ws_set;
            irq_status_second_reg <= (irq_status_second_clr ? 1'b0 :
                                      irq_status_second_reg) | spi_wake;
            shift_flag_reg <= (shift_flag_clr ? 1'b0 : shift_flag_reg)
                              | gs_hit;
            irq_pend_reg <= irq_src & ~irq_mask;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs per mode
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_pin_out                 <= 1'b0;
            rst_pin_oe_n                <= 1'b0;
            int_n_reg                   <= 1'b1;
            main_regulator_en_reg       <= 1'b1;
            aux_regulator_en_reg        <= 1'b0;
            switched_battery_output_reg <= 1'b0;
            wdog_run_reg                <= 1'b0;
        end
        else
        begin
            // Reset pin is driven low only; released it floats high
            rst_pin_out  <= 1'b0;
            rst_pin_oe_n <= !((mode_next == ST_RESET &&
                              cnt_reg < RST_CYC - 32'h1) ||
                             mode_next == ST_SLEEP ||
                             mode_next == ST_EMERG);
            int_n_reg <= !(awake_mode && |irq_pend_reg);
            main_regulator_en_reg <= !(mode_next == ST_SLEEP ||
                                       mode_next == ST_EMERG);
            aux_regulator_en_reg  <= (mode_next == ST_NORMAL);
            switched_battery_output_reg <= (mode_next == ST_NORMAL ||
                                            mode_next == ST_STANDBY);
            wdog_run_reg <= (mode_next == ST_NORMAL ||
                             mode_next == ST_STANDBY);
        end
    end
endmodule // smw_mode_ctrl

// >>> dv/smw_mode_ctrl_monitor.sv
// Concurrent checks on the ports of the mode and wake controller
`timescale 1ns/1ps
module smw_mode_ctrl_monitor (
    input wire       clk,
    input wire       rstn,
    input wire       wdog_wr,
    input wire       wdog_window_ok,
    input wire [1:0] ground_offset_level_reg,
    input wire       cs_n,
    input wire       main_regulator_low,
    input wire       main_regulator_off,
    input wire       can_tx,
    input wire [3:0] canh_below_level,
    input wire [5:0] mode_reg,
    input wire       rst_pin_oe_n,
    input wire       int_n_reg,
    input wire       main_regulator_en_reg,
    input wire       aux_regulator_en_reg,
    input wire       switched_battery_output_reg,
    input wire       irq_status_second_reg,
    input wire       shift_flag_reg,
    input wire       wdog_run_reg
);
    reg [15:0] low_cnt;
    wire       awake = mode_reg == 6'h02 || mode_reg == 6'h04
                       || mode_reg == 6'h08;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // -----------------------------------------------------------------
    // Reset drive length
    // -----------------------------------------------------------------
    // Cleared outside Reset State so a long Sleep hold is not counted
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            low_cnt <= 16'h0000;
        else if (mode_reg == 6'h01 && !rst_pin_oe_n)
            low_cnt <= low_cnt + 16'h0001;
        else
            low_cnt <= 16'h0000;
    end

    a_rst_pulse_len: assert property (
        $rose(rst_pin_oe_n) && mode_reg == 6'h01
        |-> low_cnt >= 16'h4E16 && low_cnt <= 16'h4E2A)
        else $error("reset pulse length out of range");
    a_sleep_outputs: assert property (
        mode_reg == 6'h10 && $past(mode_reg) == 6'h10
        |-> !rst_pin_oe_n && int_n_reg && !wdog_run_reg
            && !main_regulator_en_reg && !aux_regulator_en_reg)
        else $error("sleep outputs wrong");
    a_nreq_outputs: assert property (
        mode_reg == 6'h02 && $past(mode_reg) == 6'h02
        |-> rst_pin_oe_n && main_regulator_en_reg && !aux_regulator_en_reg
            && !switched_battery_output_reg)
        else $error("normal request outputs wrong");
    a_standby_outputs: assert property (
        mode_reg == 6'h08 && $past(mode_reg) == 6'h08
        |-> rst_pin_oe_n && main_regulator_en_reg && !aux_regulator_en_reg)
        else $error("stand-by outputs wrong");
    a_cs_wake: assert property (
        mode_reg == 6'h10 && main_regulator_off && $fell(cs_n)
        |-> ##[1:5] irq_status_second_reg && mode_reg == 6'h01)
        else $error("chip-select wake not taken");
    a_wdog_window: assert property (
        mode_reg == 6'h04 && wdog_wr && !wdog_window_ok
        |-> ##[1:3] mode_reg == 6'h01)
        else $error("bad watchdog write did not reset");
    a_uv_reset: assert property (
        awake && main_regulator_low |-> ##[1:5] mode_reg == 6'h01)
        else $error("undervoltage did not reset");
    a_shift_sample: assert property (
        $fell(can_tx) && canh_below_level[ground_offset_level_reg]
        |-> ##[1:5] shift_flag_reg)
        else $error("ground shift not flagged");

    c_sleep: cover property (mode_reg == 6'h10);
    c_cs_wake: cover property (mode_reg == 6'h10 && $fell(cs_n));
    c_standby: cover property (mode_reg == 6'h08);
endmodule // smw_mode_ctrl_monitor

// >>> dv/smw_host_model.sv
// Host side model: open-drain reset wire and watchdog write strobes
`timescale 1ns/1ps
module smw_host_model (
    input  wire clk,
    input  wire rstn,
    input  wire rst_pin_out,
    input  wire rst_pin_oe_n,
    input  wire hold_low,
    input  wire kick,
    input  wire kick_ok,
    output wire rst_pin_in,
    output reg  wdog_wr,
    output reg  wdog_window_ok
);
    // Pull-up wins unless the device or the host pulls the wire low
    assign rst_pin_in = (rst_pin_oe_n ? 1'b1 : rst_pin_out) & ~hold_low;

    // Window flag toggles while idle so nothing leans on a stale value
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wdog_wr        <= 1'b0;
            wdog_window_ok <= 1'b0;
        end
        else
        begin
            wdog_wr        <= kick;
            wdog_window_ok <= kick ? kick_ok : ~wdog_window_ok;
        end
    end
endmodule // smw_host_model

// >>> dv/smw_mode_ctrl_tb_top.sv
// Self-checking bench for the mode and wake controller
`timescale 1ns/1ps
`include "smw_map.vh"
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) \
    begin failures = failures + 1; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module smw_mode_ctrl_tb_top;
    reg        clk, rstn, mode_wr, cs_n, can_tx, hold_low, kick, kick_ok;
    reg        main_regulator_low, main_regulator_off;
    reg        bus_wake, forced_wake, wake_to_switched;
    reg  [2:0] mode_control_reg, mode_check_reg, local_wake_inputs, clr;
    reg  [5:0] wake_input_config_reg, fault_events;
    reg  [1:0] ground_offset_level_reg;
    reg  [3:0] canh_below_level;
    reg  [7:0] irq_mask;
    wire [5:0] mode_reg;
    wire [2:0] wake_input_status_reg, wake_input_live_state_reg;
    wire       rst_pin_out, rst_pin_oe_n, int_n_reg, main_regulator_en_reg;
    wire       aux_regulator_en_reg, switched_battery_output_reg;
    wire       irq_status_second_reg, wdog_run_reg, rst_pin_in, wdog_wr;
    wire       shift_flag_reg, wdog_window_ok;
    wire [2:0] sup = {main_regulator_en_reg, aux_regulator_en_reg,
                      switched_battery_output_reg};
    integer    failures, num_checks, i;

    smw_mode_ctrl #(.NREQ_TMO_CYC(50), .V1LOW_CYC(50)) dut (
        .*, .wdog_expired(1'b0), .cyclic_wake(1'b0),
        .wake_status_clr(clr[0]), .irq_status_second_clr(clr[1]),
        .shift_flag_clr(clr[2]));
    smw_host_model host (.*);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // -----------------------------------------------------------------
    // Access tasks
    // -----------------------------------------------------------------
    task tick(input integer c);
    begin
        repeat (c) @(posedge clk);
        #1;
    end
    endtask
    task mode_write(input [2:0] c, input [2:0] k);
    begin
        @(posedge clk);
        mode_wr <= 1'b1;
        mode_control_reg <= c;
        mode_check_reg <= k;
        @(posedge clk);
        mode_wr <= 1'b0;
        tick(3);
    end
    endtask
    task kick_wdog(input ok);
    begin
        @(posedge clk);
        kick <= 1'b1;
        kick_ok <= ok;
        @(posedge clk);
        kick <= 1'b0;
    end
    endtask
    task clear_flags(input [2:0] m);
    begin
        @(posedge clk);
        clr <= m;
        @(posedge clk);
        clr <= 3'h0;
        tick(2);
    end
    endtask
    task close_out;
    begin
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // Bounded wait; running out of cycles ends the run as a mismatch
    task wait_mode(input [5:0] m, input integer lim);
        integer k;
    begin
        k = 0;
        while (mode_reg !== m && k < lim)
        begin
            tick(1);
            k = k + 1;
        end
        `CHK(mode_reg, m)
        if (mode_reg !== m)
            close_out;
    end
    endtask

    initial
    begin
        failures = 0;
        num_checks = 0;
        {rstn, mode_wr, kick, kick_ok, main_regulator_low} = 5'h00;
        {main_regulator_off, mode_control_reg, mode_check_reg} = 7'h00;
        {bus_wake, forced_wake, wake_to_switched} = 3'h0;
        {local_wake_inputs, clr, fault_events, canh_below_level} = 16'h0000;
        {wake_input_config_reg, ground_offset_level_reg} = 8'h00;
        {cs_n, can_tx, hold_low, irq_mask} = 11'h7FF;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        tick(2);
        `CHK({mode_reg, rst_pin_oe_n, int_n_reg}, 8'h05)
        `CHK(sup, 3'h4)
        i = 2;
        while (rst_pin_oe_n !== 1'b1 && i < 25000)
        begin
            tick(1);
            i = i + 1;
        end
        `CHK(i > 19990 && i < 20010, 1'b1)
        tick(20);
        `CHK(mode_reg, 6'h01)
        @(posedge clk) hold_low <= 1'b0;
        wait_mode(6'h02, 10);
        $display("test reset done");
        @(posedge clk) wake_input_config_reg <= {4'h0, `SMW_OPT_HIGH};
        local_wake_inputs <= 3'h1;
        tick(6);
        `CHK(wake_input_status_reg, 3'h0)
        @(posedge clk) local_wake_inputs <= 3'h0;
        wait_mode(6'h10, 80);
        tick(2);
        `CHK({rst_pin_oe_n, int_n_reg, wdog_run_reg, sup}, 6'h10)
        @(posedge clk) main_regulator_off <= 1'b1;
        tick(4);
        `CHK(mode_reg, 6'h10)
        @(posedge clk) cs_n <= 1'b0;
        wait_mode(6'h01, 8);
        `CHK(irq_status_second_reg, 1'b1)
        @(posedge clk) cs_n <= 1'b1;
        main_regulator_off <= 1'b0;
        clear_flags(3'h2);
        `CHK(irq_status_second_reg, 1'b0)
        wait_mode(6'h02, 20100);
        $display("test sleep done");
        kick_wdog(1'b1);
        mode_write(`SMW_CMD_NORMAL, `SMW_CMD_STANDBY);
        `CHK(mode_reg, 6'h02)
        mode_write(`SMW_CMD_STANDBY, `SMW_CMD_STANDBY);
        `CHK(mode_reg, 6'h02)
        mode_write(`SMW_CMD_NORMAL, `SMW_CMD_NORMAL);
        `CHK({mode_reg, sup[2:1], wdog_run_reg}, 9'h027)
        @(posedge clk) irq_mask <= ~(8'h01 << `SMW_IRQ_LOCAL_WAKE);
        local_wake_inputs <= 3'h1;
        tick(6);
        `CHK(wake_input_live_state_reg, 3'h1)
        `CHK({wake_input_status_reg, int_n_reg}, 4'h2)
        @(posedge clk) local_wake_inputs <= 3'h6;
        irq_mask <= 8'hFF;
        tick(4);
        clear_flags(3'h1);
        `CHK({wake_input_live_state_reg, wake_input_status_reg}, 6'h30)
        for (i = 0; i < 8; i = i + 1)
        if (i != 6)
        begin
            @(posedge clk) fault_events <= 6'h01 << i;
            bus_wake <= (i == 7);
            irq_mask <= ~(8'h01 << i);
            tick(5);
            `CHK(int_n_reg, 1'b0)
            @(posedge clk) irq_mask <= 8'hFF;
            tick(4);
            `CHK(int_n_reg, 1'b1)
        end
        @(posedge clk) fault_events <= 6'h00;
        bus_wake <= 1'b0;
        $display("test wake and interrupt done");
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge clk) ground_offset_level_reg <= i[1:0];
            canh_below_level <= ~(4'h1 << i);
            can_tx <= 1'b0;
            tick(5);
            `CHK(shift_flag_reg, 1'b0)
            @(posedge clk) can_tx <= 1'b1;
            canh_below_level <= 4'h1 << i;
            tick(3);
            @(posedge clk) can_tx <= 1'b0;
            tick(5);
            `CHK(shift_flag_reg, 1'b1)
            @(posedge clk) can_tx <= 1'b1;
            clear_flags(3'h4);
        end
        $display("test ground shift done");
        mode_write(`SMW_CMD_STANDBY, `SMW_CMD_STANDBY);
        `CHK({mode_reg, sup[2:1]}, 8'h22)
        @(posedge clk) main_regulator_low <= 1'b1;
        wait_mode(6'h01, 8);
        @(posedge clk) main_regulator_low <= 1'b0;
        wait_mode(6'h02, 20100);
        kick_wdog(1'b1);
        tick(2);
        mode_write(`SMW_CMD_NORMAL, `SMW_CMD_NORMAL);
        `CHK(mode_reg, 6'h04)
        kick_wdog(1'b0);
        wait_mode(6'h01, 8);
        $display("test undervoltage and watchdog done");
        close_out;
    end
endmodule // smw_mode_ctrl_tb_top

bind smw_mode_ctrl smw_mode_ctrl_monitor u_mon (.*);
